// >>> fpk_framer.sv
// serial bus phy transfer framer: packet body writer with apb registers
module fpk_framer #(
  parameter int AW = 16
) (
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          phy_valid,
  input  wire logic [7:0]    phy_data,
  input  wire logic          phy_first,
  input  wire logic          phy_last,
  input  wire logic          phy_nodata,
  input  wire logic [7:0]    phy_status,
  input  wire logic [3:0]    phy_speed,
  input  wire logic          phy_iso,
  output logic               phy_ready,
  input  wire logic          buf_lost,
  input  wire logic [47:0]   rtc,
  input  wire logic [63:0]   abs_time,
  output logic               body_we,
  output logic      [AW-1:0] body_addr,
  output logic      [31:0]   body_data,
  output logic               body_done,
  output logic      [1:0]    time_fmt
);
  import fpk_pkg::*;

  localparam logic [AW-1:0] HDR_W = AW'(HDR_WORDS);
  localparam logic [AW-1:0] TSH_W = AW'(TS_HI_OFS);
  localparam logic [AW-1:0] ID_W  = AW'(ID_OFS);
  localparam logic [AW-1:0] B1_W  = AW'(BODY_FIRST);
  localparam logic [16:0]   XMAX  = 17'(MAX_XFERS);

  fpk_state_e    st_q, st_d;
  logic [31:0]   ctrl_q;
  logic [16:0]   lim_q;
  logic [AW-1:0] wlim_q;
  logic          close_q, lost_q, ovf_q, iso_q;
  logic [16:0]   cnt_q, cnt_d;
  logic [AW-1:0] ptr_q, ptr_d, hdr_q, hdr_d, wptr_q, wptr_d;
  logic [15:0]   len_q, len_d;
  logic [1:0]    code_q, code_d;
  logic [63:0]   ts_q, ts_d;
  logic [7:0]    stat_q, stat_d;
  logic [3:0]    spd_q, spd_d;
  logic          rdy_d, we_d, done_d, ovf_d, iso_d;
  logic [AW-1:0] addr_d;
  logic [31:0]   data_d;

  // timestamp word pair for the current mode
  function automatic logic [63:0] stamp(input logic absm,
                                        input logic [47:0] rel,
                                        input logic [63:0] abst);
    stamp = absm ? abst : {rel[47:32], TS_FILL, rel[31:0]};
  endfunction

  // ---------------- apb slave ----------------
  wire apb_acc  = psel & penable & ~pready;
  wire apb_done = psel & penable & pready;
  wire addr_ok  = (paddr == REG_CTRL) | (paddr == REG_LIMIT) |
                  (paddr == REG_WLIMIT) | (paddr == REG_STATUS);
  wire wr_ctrl  = apb_done & pwrite & (paddr == REG_CTRL);
  wire wr_lim   = apb_done & pwrite & (paddr == REG_LIMIT);
  wire wr_wlim  = apb_done & pwrite & (paddr == REG_WLIMIT);
  wire en       = ctrl_q[CTRL_EN];
  wire absm     = ctrl_q[CTRL_ABS];
  wire [31:0] stat_word = {12'h000, lost_q, ovf_q, (st_q != ST_IDLE),
                           cnt_q};
  wire [31:0] rd_mux =
    (paddr == REG_CTRL)   ? ctrl_q :
    (paddr == REG_LIMIT)  ? {15'h0000, lim_q} :
    (paddr == REG_WLIMIT) ? 32'(wlim_q) :
    (paddr == REG_STATUS) ? stat_word : 32'h0000_0000;

  // one wait state: ready rises the cycle after the access phase opens
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready <= apb_acc;
      if (apb_acc) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= ~addr_ok;
      end
    end
  end

  // control, limits; the close command is a sticky request
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q  <= CTRL_RST;
      lim_q   <= XMAX;
      wlim_q  <= '1;
      close_q <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) ctrl_q <= pwdata & ~(32'h1 << CTRL_CLOSE);
      if (wr_lim) lim_q <= (pwdata[16:0] > XMAX) ? XMAX : pwdata[16:0];
      if (wr_wlim) wlim_q <= pwdata[AW-1:0];
      if (wr_ctrl & pwdata[CTRL_CLOSE]) close_q <= 1'b1;
      else if (st_q == ST_CW) close_q <= 1'b0;
    end
  end

  // ---------------- phy side ----------------
  wire take     = phy_valid & phy_ready;
  // a message opens on its first byte, or on any byte after an overflow cut
  wire start    = take & (st_q == ST_IDLE) & (phy_first | ovf_q);
  wire data_in  = take & ((st_q == ST_DATA) | (start & ~phy_nodata));
  wire [15:0] max_len = iso_q ? MAX_ISO : MAX_ASYNC;
  wire [15:0] len_inc = len_q + 16'h0001;
  wire at_limit = (cnt_q >= lim_q) | (ptr_q >= wlim_q);
  wire close_go = close_q | (at_limit & (cnt_q != 17'h00000));
  wire pk_valid;
  wire [31:0] pk_word;

  // zero fill of the partial word
  fpk_word_packer u_packer (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .ce         (ce),
    .byte_valid (data_in),
    .byte_data  (phy_data),
    .flush      (st_q == ST_FLUSH),
    .word_valid (pk_valid),
    .word_data  (pk_word)
  );

  // lost flag: a new loss wins over the clear at the id write
  always_ff @(posedge mclk) begin
    if (sys_rst) lost_q <= 1'b0;
    else if (ce) lost_q <= buf_lost | (lost_q & (st_q != ST_ID));
  end

  // sequencer next state and transfer bookkeeping
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    ptr_d  = ptr_q;
    hdr_d  = hdr_q;
    wptr_d = pk_valid ? wptr_q + B1_W : wptr_q;
    len_d  = len_q;
    code_d = code_q;
    ts_d   = ts_q;
    stat_d = stat_q;
    spd_d  = spd_q;
    iso_d  = iso_q;
    ovf_d  = ovf_q;
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          // stamp taken at the first byte
          ts_d   = stamp(absm, rtc, abs_time);
          hdr_d  = ptr_q;
          wptr_d = ptr_q + HDR_W;
          if (phy_first) begin
            stat_d = phy_status;
            spd_d  = phy_speed;
            iso_d  = phy_iso;
          end
          code_d = ovf_q ? OVF_END : OVF_NONE;
          if (phy_nodata) begin
            len_d = 16'h0000;
            st_d  = ST_ID;
          end else begin
            len_d = 16'h0001;
            st_d  = phy_last ? ST_FLUSH : ST_DATA;
          end
        end else if (close_go) begin
          st_d = ST_CW;
        end
      end
      ST_DATA: begin
        if (take) begin
          len_d = len_inc;
          // cut at the limit, code by previous piece
          if (phy_last) begin
            st_d = ST_FLUSH;
          end else if (len_inc == max_len) begin
            code_d = ovf_q ? OVF_MID : OVF_START;
            st_d   = ST_FLUSH;
          end
        end
      end
      ST_FLUSH: st_d = ST_PAD;
      ST_PAD:   st_d = ST_ID;
      ST_ID:    st_d = ST_TS0;
      ST_TS0:   st_d = ST_TS1;
      ST_TS1: begin
        cnt_d = cnt_q + 17'h00001;
        ptr_d = wptr_q;
        ovf_d = (code_q == OVF_START) | (code_q == OVF_MID);
        st_d  = ST_IDLE;
      end
      ST_CW: begin
        cnt_d = 17'h00000;
        ptr_d = B1_W;
        st_d  = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // no bytes taken while a packet closes or is full
  wire full_next = (cnt_d >= lim_q) | (ptr_d >= wlim_q);
  assign rdy_d = (st_d == ST_DATA) |
                 ((st_d == ST_IDLE) & (en | ovf_d) &
                  ~((st_q == ST_IDLE) & close_go & ~start) &
                  ~((st_q == ST_TS1) & (close_q | full_next)));

  // body write port: packed data first, header words in their states
  always_comb begin
    we_d   = 1'b1;
    done_d = 1'b0;
    addr_d = wptr_q;
    data_d = pk_word;
    if (!pk_valid) begin
      case (st_q)
        ST_ID: begin
          addr_d = hdr_q + ID_W;
          data_d = {stat_q, spd_q, code_q, lost_q, 1'b0, len_q};
        end
        ST_TS0: begin
          addr_d = hdr_q;
          data_d = ts_q[31:0];
        end
        ST_TS1: begin
          addr_d = hdr_q + TSH_W;
          data_d = ts_q[63:32];
        end
        // channel word at the body start
        ST_CW: begin
          addr_d = '0;
          data_d = {CW_SPARE, cnt_q[15:0]};
          done_d = 1'b1;
        end
        default: we_d = 1'b0;
      endcase
    end
  end

  // state registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q   <= ST_IDLE;
      cnt_q  <= 17'h00000;
      ptr_q  <= B1_W;
      hdr_q  <= B1_W;
      wptr_q <= B1_W;
      len_q  <= 16'h0000;
      code_q <= OVF_NONE;
      ts_q   <= 64'h0000_0000_0000_0000;
      stat_q <= 8'h00;
      spd_q  <= 4'h0;
      iso_q  <= 1'b0;
      ovf_q  <= 1'b0;
    end else if (ce) begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      ptr_q  <= ptr_d;
      hdr_q  <= hdr_d;
      wptr_q <= wptr_d;
      len_q  <= len_d;
      code_q <= code_d;
      ts_q   <= ts_d;
      stat_q <= stat_d;
      spd_q  <= spd_d;
      iso_q  <= iso_d;
      ovf_q  <= ovf_d;
    end
  end

  // registered outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      phy_ready <= 1'b0;
      body_we   <= 1'b0;
      body_addr <= '0;
      body_data <= 32'h0000_0000;
      body_done <= 1'b0;
      time_fmt  <= 2'h0;
    end else if (ce) begin
      phy_ready <= rdy_d;
      body_we   <= we_d;
      body_addr <= addr_d;
      body_data <= data_d;
      body_done <= done_d;
      time_fmt  <= ctrl_q[CTRL_TFMT_LO +: 2];
    end
  end

  // ---------------- checks ----------------
  sequence s_hdr_tail;
    st_q == ST_TS0 ##1 st_q == ST_TS1 ##1 st_q == ST_IDLE;
  endsequence

  a_chan_word_pos: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    body_done |-> body_we && body_addr == '0 &&
                  body_data[31:16] == CW_SPARE)
    else $error("channel word not at body start");

  a_count_written: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    st_q == ST_CW |=> body_data[15:0] == $past(cnt_q[15:0]) &&
                      cnt_q == 17'h00000 && ptr_q == B1_W)
    else $error("intra count not written or not restarted");

  a_hdr_seq_order: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    st_q == ST_ID |=> s_hdr_tail)
    else $error("header words out of order");

  a_id_len_lost: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    st_q == ST_ID && !pk_valid |=>
      body_data[ID_LOST] == $past(lost_q) &&
      body_data[15:0] == $past(len_q) && body_data[16] == 1'b0)
    else $error("id word lost flag or length wrong");

  a_len_bound: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    st_q == ST_ID |-> len_q <= max_len)
    else $error("byte count above maximum");

  a_pad_align: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    st_q == ST_ID |-> wptr_q - hdr_q ==
      HDR_W + AW'((17'(len_q) + 17'h00003) >> 2))
    else $error("data not padded to whole words");

  a_ovf_cut_code: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    st_q == ST_DATA && take && !phy_last && len_inc == max_len |=>
      st_q == ST_FLUSH && code_q[0] == 1'b1)
    else $error("overlong transfer not cut");

  a_ts_low_fill: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    start && !absm |=> ts_q[47:32] == TS_FILL &&
      ts_q[31:0] == $past(rtc[31:0]) && ts_q[63:48] == $past(rtc[47:32]))
    else $error("relative stamp fill not zero");

  a_nodata_hdr: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    start && phy_nodata |=> st_q == ST_ID && len_q == 16'h0000)
    else $error("empty transfer carries data");

  a_close_stall: assert property (
    @(posedge mclk) disable iff (sys_rst || !ce)
    st_q == ST_CW |-> !phy_ready)
    else $error("bytes accepted while closing packet");

endmodule // fpk_framer

// >>> fpk_pkg.sv
// constants and types shared by the transfer packetizer files
package fpk_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_LIMIT  = 8'h04;
  localparam logic [7:0] REG_WLIMIT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;

  // control register fields (time bits mirror the packet flags)
  localparam int CTRL_EN      = 0;
  localparam int CTRL_CLOSE   = 1;
  localparam int CTRL_TFMT_LO = 2;
  localparam int CTRL_ABS     = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // status register fields
  localparam int STAT_OPEN = 17;
  localparam int STAT_OVF  = 18;
  localparam int STAT_LOST = 19;

  // message id word field positions
  localparam int ID_STAT_LO  = 24;
  localparam int ID_SPEED_LO = 20;
  localparam int ID_OVF_LO   = 18;
  localparam int ID_LOST     = 17;

  // transfer overflow codes
  localparam logic [1:0] OVF_NONE  = 2'h0;
  localparam logic [1:0] OVF_START = 2'h1;
  localparam logic [1:0] OVF_END   = 2'h2;
  localparam logic [1:0] OVF_MID   = 2'h3;

  // transmission speed codes written as received from the phy
  localparam logic [3:0] SPD_S100A  = 4'h0;
  localparam logic [3:0] SPD_S100B  = 4'h1;
  localparam logic [3:0] SPD_S200A  = 4'h2;
  localparam logic [3:0] SPD_S200B  = 4'h3;
  localparam logic [3:0] SPD_S400A  = 4'h4;
  localparam logic [3:0] SPD_S400B  = 4'h5;
  localparam logic [3:0] SPD_S800B  = 4'h7;
  localparam logic [3:0] SPD_S1600B = 4'h9;
  localparam logic [3:0] SPD_S3200B = 4'hA;

  // longest captured transfer in bytes
  localparam logic [15:0] MAX_ASYNC = 16'h1018;
  localparam logic [15:0] MAX_ISO   = 16'h800C;

  // packet layout
  localparam int MAX_XFERS   = 65536;
  localparam int HDR_WORDS   = 3;
  localparam int TS_HI_OFS   = 1;
  localparam int ID_OFS      = 2;
  localparam int BODY_FIRST  = 1;
  localparam logic [15:0] CW_SPARE = 16'h0000;
  localparam logic [15:0] TS_FILL  = 16'h0000;

  // framer sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_DATA, ST_FLUSH, ST_PAD, ST_ID, ST_TS0, ST_TS1, ST_CW
  } fpk_state_e;

endpackage

// >>> fpk_word_packer.sv
// packs a byte stream into little-endian 32-bit words with zero fill
module fpk_word_packer (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  input  wire logic        flush,
  output logic             word_valid,
  output logic [31:0]      word_data
);
  import fpk_pkg::*;

  logic [31:0] acc_q;
  logic [1:0]  lane_q;
  logic [31:0] acc_d;
  logic        full;
  logic        flush_go;

  // place the byte in its lane; unused lanes stay zero as fill
  always_comb begin
    acc_d = acc_q;
    if (byte_valid) begin
      acc_d[{lane_q, 3'h0} +: 8] = byte_data;
    end
  end

  assign full     = byte_valid & (lane_q == 2'h3);
  assign flush_go = flush & (lane_q != 2'h0);

  // word is released on the fourth byte or on a flush of a partial word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc_q      <= 32'h0000_0000;
      lane_q     <= 2'h0;
      word_valid <= 1'b0;
      word_data  <= 32'h0000_0000;
    end else if (ce) begin
      word_valid <= full | flush_go;
      if (full | flush_go) begin
        word_data <= acc_d;
        acc_q     <= 32'h0000_0000;
        lane_q    <= 2'h0;
      end else begin
        acc_q  <= acc_d;
        lane_q <= lane_q + {1'b0, byte_valid};
      end
    end
  end

endmodule // fpk_word_packer

// >>> fpk_phy_model.sv
// behavioural phy layer source offering one message per start pulse
module fpk_phy_model (
  input  wire logic        mclk,
  input  wire logic        start,
  input  wire logic [15:0] n_bytes,
  input  wire logic [7:0]  base,
  input  wire logic        nodata,
  input  wire logic [7:0]  st,
  input  wire logic [3:0]  sp,
  input  wire logic        iso,
  input  wire logic        slow,
  input  wire logic        phy_ready,
  output logic             phy_valid,
  output logic [7:0]       phy_data,
  output logic             phy_first,
  output logic             phy_last,
  output logic             phy_nodata,
  output logic [7:0]       phy_status,
  output logic [3:0]       phy_speed,
  output logic             phy_iso,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  int total = 0;
  bit gap = 1'b0;
  // quiet lines at time zero
  initial begin
    phy_valid = 1'b0;
    phy_data = 8'h00;
    phy_first = 1'b0;
    phy_last = 1'b0;
    phy_nodata = 1'b0;
    phy_status = 8'h00;
    phy_speed = 4'h0;
    phy_iso = 1'b0;
  end
  assign busy = idx < total;
  // one whole message, first to last byte
  always @(posedge mclk) begin
    if (phy_valid && phy_ready) begin
      idx = idx + 1;
      gap = slow; // slow source idles a cycle between bytes
    end
    if (start) begin
      idx = 0;
      total = int'(n_bytes);
      phy_status <= st;
      phy_speed <= sp;
      phy_iso <= iso;
    end
    // an offered byte is held until it is taken
    if (!phy_valid || phy_ready) begin
      if (idx < total && !gap) begin
        phy_valid <= 1'b1;
        phy_data <= base + idx[7:0];
        phy_first <= idx == 0;
        phy_last <= idx == total - 1;
        phy_nodata <= nodata && idx == 0;
      end else begin
        phy_valid <= 1'b0;
        phy_data <= ~phy_data; // released line does not keep its value
        phy_first <= 1'b0;
        phy_last <= 1'b0;
        phy_nodata <= 1'b0;
        gap = 1'b0;
      end
    end
  end
endmodule // fpk_phy_model

// >>> tb_ieee1394_phy_transfer_packetizer.sv
// self-checking bench for the phy transfer packetizer
module tb_ieee1394_phy_transfer_packetizer;
  timeunit 1ns;
  timeprecision 1ps;
  import fpk_pkg::*;
  localparam logic [3:0] SPDS [9] = '{SPD_S100A, SPD_S100B, SPD_S200A,
    SPD_S200B, SPD_S400A, SPD_S400B, SPD_S800B, SPD_S1600B, SPD_S3200B};
  logic mclk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, body_data, cw;
  logic pready, pslverr, phy_valid, phy_first, phy_last, phy_nodata, phy_iso;
  logic [7:0] phy_data, phy_status, m_base = 0, m_st = 0;
  logic [3:0] phy_speed, m_sp = 0;
  logic phy_ready, buf_lost = 0, body_we, body_done, busy;
  logic [47:0] rtc = 0;
  logic [63:0] abs_time = 0;
  logic [15:0] body_addr, cw_addr, m_n = 0;
  logic [1:0] time_fmt;
  logic start = 0, m_nd = 0, m_iso = 0, m_slow = 0;
  logic [31:0] mem [0:4095];
  int n_errors = 0, checks_done = 0, n_done = 0, exp_done = 0, p = 1;
  always #10 mclk = ~mclk;
  fpk_framer #(.AW(16)) uut (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_valid(phy_valid), .phy_data(phy_data), .phy_first(phy_first),
    .phy_last(phy_last), .phy_nodata(phy_nodata), .phy_status(phy_status),
    .phy_speed(phy_speed), .phy_iso(phy_iso), .phy_ready(phy_ready),
    .buf_lost(buf_lost), .rtc(rtc), .abs_time(abs_time), .body_we(body_we),
    .body_addr(body_addr), .body_data(body_data), .body_done(body_done),
    .time_fmt(time_fmt));
  fpk_phy_model phy (.mclk(mclk), .start(start), .n_bytes(m_n),
    .base(m_base), .nodata(m_nd), .st(m_st), .sp(m_sp), .iso(m_iso),
    .slow(m_slow), .phy_ready(phy_ready), .phy_valid(phy_valid),
    .phy_data(phy_data), .phy_first(phy_first), .phy_last(phy_last),
    .phy_nodata(phy_nodata), .phy_status(phy_status),
    .phy_speed(phy_speed), .phy_iso(phy_iso), .busy(busy));
  // body memory image and packet close capture
  always @(posedge mclk) begin
    if (body_we) mem[body_addr[11:0]] <= body_data;
    if (body_done) begin
      n_done <= n_done + 1;
      cw <= body_data;
      cw_addr <= body_addr;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb_wait", 32'(n >= 50), 32'h0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, exp);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk("reg_read", rd & m, exp);
    chk("rd_err", {31'h0, e}, 32'h0);
  endtask
  // start one message on the phy model and wait for the framer to idle
  task automatic send(input logic [15:0] n, input logic [7:0] sd,
                      input logic nd, input logic [7:0] st,
                      input logic [3:0] sp, input logic iso, input logic sl);
    int k;
    @(posedge mclk);
    m_n <= n;
    m_base <= sd;
    m_nd <= nd;
    m_st <= st;
    m_sp <= sp;
    m_iso <= iso;
    m_slow <= sl;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (busy && k < 20000);
    repeat (2) @(posedge mclk);
    while (phy_ready !== 1'b1 && k < 20100) begin
      @(negedge mclk);
      k++;
    end
    repeat (3) @(posedge mclk);
    chk("idle_wait", 32'(k >= 20000), 32'h0);
  endtask
  function automatic logic [63:0] rel_ts();
    return {rtc[47:32], 16'h0000, rtc[31:0]};
  endfunction
  // compare one intra packet in the body image and step past it
  task automatic chk_xfer(input logic [7:0] st, input logic [3:0] sp,
                          input logic [1:0] ov, input logic lost,
                          input int len, input logic [63:0] ts,
                          input logic [7:0] b0);
    logic [31:0] w;
    chk("ts_lo", mem[p], ts[31:0]);
    chk("ts_hi", mem[p+1], ts[63:32]);
    chk("id", mem[p+2], {st, sp, ov, lost, 1'b0, 16'(len)});
    for (int k = 0; k < (len + 3) / 4; k++) begin
      for (int l = 0; l < 4; l++)
        w[8*l+:8] = (4*k + l < len) ? b0 + 8'(4*k + l) : 8'h00;
      chk("data", mem[p+3+k], w);
    end
    p = p + 3 + (len + 3) / 4;
  endtask
  task automatic close_chk(input logic [31:0] ctrl_v, input logic [15:0] c);
    logic [31:0] rd;
    logic e;
    int n;
    if (ctrl_v[CTRL_CLOSE]) apb(1'b1, REG_CTRL, ctrl_v, rd, e);
    exp_done++;
    n = 0;
    while (n_done != exp_done && n < 100) begin
      @(negedge mclk);
      n++;
    end
    chk("done", 32'(n_done), 32'(exp_done));
    chk("cw", cw, {16'h0000, c});
    chk("cw_addr", {16'h0000, cw_addr}, 32'h0);
    p = 1;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
  initial begin
    logic [31:0] rd;
    logic e;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    rd_chk(REG_CTRL, 32'hFFFF_FFFF, CTRL_RST);
    rd_chk(REG_LIMIT, 32'hFFFF_FFFF, 32'h0001_0000);
    rd_chk(REG_STATUS, 32'h000D_FFFF, 32'h0);
    apb(1'b0, 8'h10, 32'h0, rd, e);
    chk("bad_err", {31'h0, e}, 32'h1);
    chk("bad_rd", rd, 32'h0);
    apb(1'b1, REG_LIMIT, 32'hFFFF_FFFF, rd, e);
    rd_chk(REG_LIMIT, 32'hFFFF_FFFF, 32'h0001_0000);
    apb(1'b1, REG_CTRL, 32'h0000_0009, rd, e);
    repeat (2) @(posedge mclk);
    chk("time_fmt", {30'h0, time_fmt}, 32'h2);
    rtc <= 48'h1234_5678_9ABC;
    send(16'd5, 8'h10, 1'b0, 8'hA5, SPD_S400B, 1'b0, 1'b1);
    chk_xfer(8'hA5, SPD_S400B, OVF_NONE, 1'b0, 5, rel_ts(), 8'h10);
    @(posedge mclk) buf_lost <= 1'b1;
    @(posedge mclk) buf_lost <= 1'b0;
    send(16'd1, 8'h00, 1'b1, 8'h3C, SPD_S100A, 1'b0, 1'b0);
    chk_xfer(8'h3C, SPD_S100A, OVF_NONE, 1'b1, 0, rel_ts(), 8'h0);
    for (int i = 0; i < 9; i++) begin
      rtc <= rtc + 48'h0001_0000_0101;
      send(16'd1, 8'(i * 7), 1'b0, 8'(i), SPDS[i], 1'b1, 1'b0);
      chk_xfer(8'(i), SPDS[i], OVF_NONE, 1'b0, 1, rel_ts(), 8'(i * 7));
    end
    rd_chk(REG_STATUS, 32'h000D_FFFF, 32'd11);
    close_chk(32'h0000_000B, 16'd11);
    apb(1'b1, REG_CTRL, 32'h0000_0049, rd, e);
    abs_time <= 64'hFEDC_BA98_7654_3210;
    send(16'd4, 8'h40, 1'b0, 8'h11, SPD_S800B, 1'b1, 1'b0);
    chk_xfer(8'h11, SPD_S800B, OVF_NONE, 1'b0, 4, abs_time, 8'h40);
    send(16'd8250, 8'h20, 1'b0, 8'h81, SPD_S200B, 1'b0, 1'b0);
    chk_xfer(8'h81, SPD_S200B, OVF_START, 1'b0, 4120, abs_time, 8'h20);
    chk_xfer(8'h81, SPD_S200B, OVF_MID, 1'b0, 4120, abs_time, 8'h38);
    chk_xfer(8'h81, SPD_S200B, OVF_END, 1'b0, 10, abs_time, 8'h50);
    close_chk(32'h0000_004B, 16'd4);
    apb(1'b1, REG_LIMIT, 32'h0000_0002, rd, e);
    apb(1'b1, REG_CTRL, 32'h0000_0001, rd, e);
    send(16'd3, 8'h60, 1'b0, 8'h22, SPD_S1600B, 1'b1, 1'b1);
    send(16'd3, 8'h70, 1'b0, 8'h33, SPD_S3200B, 1'b1, 1'b0);
    chk_xfer(8'h22, SPD_S1600B, OVF_NONE, 1'b0, 3, rel_ts(), 8'h60);
    chk_xfer(8'h33, SPD_S3200B, OVF_NONE, 1'b0, 3, rel_ts(), 8'h70);
    close_chk(32'h0000_0001, 16'd2);
    print_verdict();
  end
endmodule // tb_ieee1394_phy_transfer_packetizer
